// *** core/srht_pkg.sv ***
// constants, types and stage tables of the system-register hazard timing block
`default_nettype none
package srht_pkg;

    // ------------------------------------------------------------
    // widths and pipeline depth
    // ------------------------------------------------------------
    localparam int unsigned PIPE_STAGES = 6;
    localparam int unsigned GPR_W = 5;
    localparam int unsigned SYSREG_W = 5;
    localparam int unsigned RES_W = 5;
    localparam int unsigned STG_W = 3;

    // ------------------------------------------------------------
    // contended resource classes, one bit each
    // ------------------------------------------------------------
    localparam logic [RES_W-1:0] RES_NONE = 5'h00;
    localparam logic [RES_W-1:0] RES_SYSREG = 5'h01;
    localparam logic [RES_W-1:0] RES_TLB = 5'h02;
    localparam logic [RES_W-1:0] RES_INDEX = 5'h04;
    localparam logic [RES_W-1:0] RES_ENTRY = 5'h08;
    localparam logic [RES_W-1:0] RES_STATUS = 5'h10;
    localparam logic [RES_W-1:0] RES_ANY_SYS = 5'h1D;

    // ------------------------------------------------------------
    // stage numbers at which state is read (src) or written (dst)
    // ------------------------------------------------------------
    localparam logic [STG_W-1:0] STG_NONE = 3'h0;
    localparam logic [STG_W-1:0] MOVE_TO_SRC_STG = 3'h1;
    localparam logic [STG_W-1:0] MOVE_TO_DST_STG = 3'h5;
    localparam logic [STG_W-1:0] MOVE_FROM_SRC_STG = 3'h3;
    localparam logic [STG_W-1:0] TLB_READ_SRC_STG = 3'h2;
    localparam logic [STG_W-1:0] TLB_READ_DST_STG = 3'h5;
    localparam logic [STG_W-1:0] TLB_WRITE_SRC_STG = 3'h2;
    localparam logic [STG_W-1:0] TLB_WRITE_DST_STG = 3'h5;
    localparam logic [STG_W-1:0] TLB_PROBE_SRC_STG = 3'h2;
    localparam logic [STG_W-1:0] TLB_PROBE_DST_STG = 3'h6;
    localparam logic [STG_W-1:0] RETURN_SRC_STG = 3'h2;
    localparam logic [STG_W-1:0] RETURN_DST_STG = 3'h4;
    localparam logic [STG_W-1:0] LDST_SRC_STG = 3'h3;
    localparam logic [STG_W-1:0] COPROC_SRC_STG = 3'h2;
    localparam logic [STG_W-1:0] IRQ_SRC_STG = 3'h2;
    localparam logic [STG_W-1:0] SHUT_INST_DST_STG = 3'h2;
    localparam logic [STG_W-1:0] SHUT_DATA_DST_STG = 3'h4;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        other_op, move_to_sysreg, move_from_sysreg, tlb_read_op, tlb_write_indexed_op,
        tlb_write_random_op, tlb_probe_op, exception_return_op, load_store_op, coproc_op
    } srht_kind_t;

    typedef struct packed {
        logic valid;
        srht_kind_t kind;
        logic [SYSREG_W-1:0] sysctl_reg_n;
        logic [GPR_W-1:0] src_a;
        logic [GPR_W-1:0] src_b;
        logic [GPR_W-1:0] dst;
        logic dst_we;
        logic shut_inst;
        logic shut_data;
    } srht_op_t;

    typedef struct packed {
        logic sysreg_write;
        logic sysreg_read;
        logic tlb_read_src;
        logic tlb_write_src;
        logic tlb_write;
        logic entry_write;
        logic probe_src;
        logic index_write;
        logic ret_read;
        logic ret_flags;
        logic irq_sample;
        logic usable_check;
        logic ldst_sample;
        logic shutdown_write;
    } srht_strobe_t;

    // ------------------------------------------------------------
    // per-kind timing tables
    // ------------------------------------------------------------
    function automatic logic [STG_W-1:0] srht_src_stage(input srht_kind_t k);
        case (k)
            move_to_sysreg: return MOVE_TO_SRC_STG;
            move_from_sysreg: return MOVE_FROM_SRC_STG;
            tlb_read_op: return TLB_READ_SRC_STG;
            tlb_write_indexed_op, tlb_write_random_op: return TLB_WRITE_SRC_STG;
            tlb_probe_op: return TLB_PROBE_SRC_STG;
            exception_return_op: return RETURN_SRC_STG;
            load_store_op: return LDST_SRC_STG;
            coproc_op: return COPROC_SRC_STG;
            default: return STG_NONE;
        endcase
    endfunction

    function automatic logic [STG_W-1:0] srht_dst_stage(input srht_kind_t k);
        case (k)
            move_to_sysreg: return MOVE_TO_DST_STG;
            tlb_read_op: return TLB_READ_DST_STG;
            tlb_write_indexed_op, tlb_write_random_op: return TLB_WRITE_DST_STG;
            tlb_probe_op: return TLB_PROBE_DST_STG;
            exception_return_op: return RETURN_DST_STG;
            default: return STG_NONE;
        endcase
    endfunction

    function automatic logic [RES_W-1:0] srht_src_res(input srht_kind_t k);
        case (k)
            move_from_sysreg: return RES_ANY_SYS;
            tlb_read_op: return RES_INDEX | RES_TLB;
            tlb_write_indexed_op, tlb_write_random_op: return RES_INDEX | RES_ENTRY;
            tlb_probe_op: return RES_ENTRY;
            exception_return_op: return RES_SYSREG | RES_TLB | RES_STATUS;
            load_store_op: return RES_ENTRY | RES_STATUS | RES_SYSREG | RES_TLB;
            coproc_op: return RES_STATUS;
            default: return RES_NONE;
        endcase
    endfunction

    function automatic logic [RES_W-1:0] srht_dst_res(input srht_kind_t k);
        case (k)
            move_to_sysreg: return RES_ANY_SYS;
            tlb_read_op: return RES_ENTRY;
            tlb_write_indexed_op, tlb_write_random_op: return RES_TLB;
            tlb_probe_op: return RES_INDEX;
            exception_return_op: return RES_STATUS;
            default: return RES_NONE;
        endcase
    endfunction

endpackage
`default_nettype wire

// *** core/srht_core.sv ***
// pipeline stage timing, load-use interlock and spacing check for system-control state
`default_nettype none
module srht_core #(
    parameter int unsigned NUM_STAGES = srht_pkg::PIPE_STAGES
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic enable_i,
    input wire srht_pkg::srht_op_t issue_i,
    output logic issue_ready_o,
    output var srht_pkg::srht_strobe_t strobes_o,
    output logic [srht_pkg::SYSREG_W-1:0] sysreg_wr_n_o,
    output logic [srht_pkg::SYSREG_W-1:0] sysreg_rd_n_o,
    output logic hazard_o,
    output logic [srht_pkg::STG_W-1:0] hazard_gap_o
);
    import srht_pkg::*;

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (NUM_STAGES < 6) begin : g_depth_check
        $error("srht_core needs at least six stages");
    end

    srht_op_t pipe_reg [NUM_STAGES];
    srht_op_t pipe_next [NUM_STAGES];
    logic hazard_reg, hazard_next;
    logic [STG_W-1:0] gap_reg, gap_next;
    logic late_dep, taken;
    logic [STG_W-1:0] stage_gap [NUM_STAGES-1];

    // ------------------------------------------------------------
    // interlock
    // ------------------------------------------------------------
    // load-use stall
    // only loads and move-from deliver late; everything else is forwarded
    assign late_dep = issue_i.valid && pipe_reg[0].valid && pipe_reg[0].dst_we
        && (pipe_reg[0].dst != '0)
        && (pipe_reg[0].kind == load_store_op || pipe_reg[0].kind == move_from_sysreg)
        && (pipe_reg[0].dst == issue_i.src_a || pipe_reg[0].dst == issue_i.src_b);
    // no system-state interlock
    // ready depends on the gpr match alone, so system hazards never stall
    assign issue_ready_o = !late_dep;
    assign taken = enable_i && issue_i.valid && !late_dep;

    // ------------------------------------------------------------
    // spacing check against every older instruction in stages 1 to NUM_STAGES-1
    // ------------------------------------------------------------
    for (genvar j = 0; j < NUM_STAGES - 1; j++) begin : g_gap
        logic [3:0] reach, dstg;
        logic hit, same_n;
        // missing filler count
        // older op sits at stage j+2 when the new one enters stage 1
        always_comb begin
            reach = 4'(j) + 4'h1 + {1'b0, srht_src_stage(issue_i.kind)};
            dstg = {1'b0, srht_dst_stage(pipe_reg[j].kind)};
            same_n = !(pipe_reg[j].kind == move_to_sysreg
                && issue_i.kind == move_from_sysreg)
                || (pipe_reg[j].sysctl_reg_n == issue_i.sysctl_reg_n);
            hit = pipe_reg[j].valid && same_n && (reach < dstg)
                && ((srht_dst_res(pipe_reg[j].kind) & srht_src_res(issue_i.kind)) != '0);
            stage_gap[j] = hit ? STG_W'(dstg - reach) : '0;
        end
    end

    // ------------------------------------------------------------
    // next state of pipe and hazard report
    // ------------------------------------------------------------
    // a stalled issue leaves a bubble in stage 1
    always_comb begin
        for (int k = 0; k < NUM_STAGES; k++) begin
            pipe_next[k] = pipe_reg[k];
        end
        hazard_next = hazard_reg;
        gap_next = gap_reg;
        if (enable_i) begin
            pipe_next[0] = taken ? issue_i : '0;
            for (int k = 1; k < NUM_STAGES; k++) begin
                pipe_next[k] = pipe_reg[k-1];
            end
            gap_next = '0;
            // report, not repair, missing fillers
            // worst older producer wins; cleared to zero in any enabled cycle that takes no issue
            for (int k = 0; k < NUM_STAGES - 1; k++) begin
                if (taken && stage_gap[k] > gap_next) begin
                    gap_next = stage_gap[k];
                end
            end
            hazard_next = (gap_next != '0);
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            for (int k = 0; k < NUM_STAGES; k++) begin
                pipe_reg[k] <= '0;
            end
            hazard_reg <= 1'b0;
            gap_reg <= '0;
        end else begin
            pipe_reg <= pipe_next;
            hazard_reg <= hazard_next;
            gap_reg <= gap_next;
        end
    end

    assign hazard_o = hazard_reg;
    assign hazard_gap_o = gap_reg;

    // ------------------------------------------------------------
    // stage strobes, decoded from the pipe flops
    // ------------------------------------------------------------
    // move-to and move-from stages
    assign strobes_o.sysreg_write = pipe_reg[MOVE_TO_DST_STG-1].valid
        && pipe_reg[MOVE_TO_DST_STG-1].kind == move_to_sysreg;
    assign strobes_o.sysreg_read = pipe_reg[MOVE_FROM_SRC_STG-1].valid
        && pipe_reg[MOVE_FROM_SRC_STG-1].kind == move_from_sysreg;
    assign sysreg_wr_n_o = pipe_reg[MOVE_TO_DST_STG-1].sysctl_reg_n;
    assign sysreg_rd_n_o = pipe_reg[MOVE_FROM_SRC_STG-1].sysctl_reg_n;
    assign strobes_o.tlb_read_src = pipe_reg[TLB_READ_SRC_STG-1].valid
        && pipe_reg[TLB_READ_SRC_STG-1].kind == tlb_read_op;
    assign strobes_o.entry_write = pipe_reg[TLB_READ_DST_STG-1].valid
        && pipe_reg[TLB_READ_DST_STG-1].kind == tlb_read_op;
    assign strobes_o.tlb_write_src = pipe_reg[TLB_WRITE_SRC_STG-1].valid
        && (pipe_reg[TLB_WRITE_SRC_STG-1].kind == tlb_write_indexed_op
        || pipe_reg[TLB_WRITE_SRC_STG-1].kind == tlb_write_random_op);
    assign strobes_o.tlb_write = pipe_reg[TLB_WRITE_DST_STG-1].valid
        && (pipe_reg[TLB_WRITE_DST_STG-1].kind == tlb_write_indexed_op
        || pipe_reg[TLB_WRITE_DST_STG-1].kind == tlb_write_random_op);
    assign strobes_o.probe_src = pipe_reg[TLB_PROBE_SRC_STG-1].valid
        && pipe_reg[TLB_PROBE_SRC_STG-1].kind == tlb_probe_op;
    assign strobes_o.index_write = pipe_reg[TLB_PROBE_DST_STG-1].valid
        && pipe_reg[TLB_PROBE_DST_STG-1].kind == tlb_probe_op;
    assign strobes_o.ret_read = pipe_reg[RETURN_SRC_STG-1].valid
        && pipe_reg[RETURN_SRC_STG-1].kind == exception_return_op;
    assign strobes_o.ret_flags = pipe_reg[RETURN_DST_STG-1].valid
        && pipe_reg[RETURN_DST_STG-1].kind == exception_return_op;
    assign strobes_o.irq_sample = pipe_reg[IRQ_SRC_STG-1].valid;
    assign strobes_o.usable_check = pipe_reg[COPROC_SRC_STG-1].valid
        && pipe_reg[COPROC_SRC_STG-1].kind == coproc_op;
    assign strobes_o.ldst_sample = pipe_reg[LDST_SRC_STG-1].valid
        && pipe_reg[LDST_SRC_STG-1].kind == load_store_op;
    assign strobes_o.shutdown_write =
        (pipe_reg[SHUT_INST_DST_STG-1].valid && pipe_reg[SHUT_INST_DST_STG-1].shut_inst)
        || (pipe_reg[SHUT_DATA_DST_STG-1].valid && pipe_reg[SHUT_DATA_DST_STG-1].shut_data);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    load_use_stall_a: assert property (
        issue_i.valid && pipe_reg[0].valid && pipe_reg[0].kind == load_store_op
        && pipe_reg[0].dst_we && pipe_reg[0].dst != '0 && pipe_reg[0].dst == issue_i.src_a
        |-> !issue_ready_o) else $error("load-use dependence not stalled");
    no_sys_stall_a: assert property (
        !issue_ready_o |-> issue_i.valid && pipe_reg[0].valid
        && (pipe_reg[0].kind == load_store_op || pipe_reg[0].kind == move_from_sysreg))
        else $error("stall without gpr cause");
    move_to_write_a: assert property (
        taken && issue_i.kind == move_to_sysreg ##1 enable_i [*4]
        |=> strobes_o.sysreg_write) else $error("move-to write not at stage 5");
    move_from_read_a: assert property (
        taken && issue_i.kind == move_from_sysreg ##1 enable_i [*2]
        |=> strobes_o.sysreg_read && sysreg_rd_n_o == $past(issue_i.sysctl_reg_n, 3))
        else $error("move-from read not at stage 3");
    ret_flags_a: assert property (
        taken && issue_i.kind == exception_return_op ##1 enable_i [*3]
        |=> strobes_o.ret_flags && $past(strobes_o.ret_read, 2))
        else $error("return timing wrong");
    irq_sample_a: assert property (
        taken ##1 enable_i |=> strobes_o.irq_sample) else $error("interrupt sample missed");
    usable_check_a: assert property (
        taken && issue_i.kind == coproc_op ##1 enable_i |=> strobes_o.usable_check)
        else $error("usable check not at stage 2");
    ldst_sample_a: assert property (
        taken && issue_i.kind == load_store_op ##1 enable_i [*2] |=> strobes_o.ldst_sample)
        else $error("load/store sample not at stage 3");
    probe_index_a: assert property (
        taken && issue_i.kind == tlb_probe_op ##1 enable_i [*5] |=> strobes_o.index_write)
        else $error("probe index write not at stage 6");
    shut_data_a: assert property (
        taken && issue_i.shut_data ##1 enable_i [*3] |=> strobes_o.shutdown_write)
        else $error("data shutdown flag not at stage 4");
    adjacent_gap_a: assert property (
        taken && issue_i.kind == move_to_sysreg ##1 taken && issue_i.kind == move_from_sysreg
        && issue_i.sysctl_reg_n == $past(issue_i.sysctl_reg_n)
        |=> hazard_o && hazard_gap_o == 3'h1) else $error("missing filler not reported");
    probe_gap_a: assert property (
        taken && issue_i.kind == tlb_probe_op ##1 taken && issue_i.kind == move_from_sysreg
        |=> hazard_gap_o == 3'h2) else $error("probe to read gap not 2");
    // move-from results arrive late like loads, so they must stall as well
    move_from_stall_a: assert property (
        issue_i.valid && pipe_reg[0].valid && pipe_reg[0].kind == move_from_sysreg
        && pipe_reg[0].dst_we && pipe_reg[0].dst != '0 && pipe_reg[0].dst == issue_i.src_a
        |-> !issue_ready_o) else $error("move-from dependence not stalled");
    // the bubble left by a stall can never match, so a stall lasts one cycle
    one_stall_a: assert property (
        !issue_ready_o && enable_i |=> issue_ready_o) else $error("stall longer than one cycle");
    shut_inst_a: assert property (
        taken && issue_i.shut_inst ##1 enable_i |=> strobes_o.shutdown_write)
        else $error("fetch shutdown flag not at stage 2");
    tlb_write_a: assert property (
        taken && (issue_i.kind == tlb_write_indexed_op || issue_i.kind == tlb_write_random_op)
        ##1 enable_i [*4] |=> strobes_o.tlb_write && $past(strobes_o.tlb_write_src, 3))
        else $error("tlb write not at stage 5");
    entry_write_a: assert property (
        taken && issue_i.kind == tlb_read_op ##1 enable_i [*4]
        |=> strobes_o.entry_write && $past(strobes_o.tlb_read_src, 3))
        else $error("entry write not at stage 5");
    hazard_idle_a: assert property (
        enable_i && !taken |=> !hazard_o && hazard_gap_o == 3'h0) else $error("stale hazard");
    // a frozen pipe must not move a strobe, or stage timing slips silently
    frozen_pipe_a: assert property (
        !enable_i |=> $stable(strobes_o) && $stable(hazard_gap_o)) else $error("frozen pipe moved");

endmodule
`default_nettype wire

// *** core/unused_placeholder_none.sv ***
// intentionally empty design unit list
`default_nettype none
`default_nettype wire

// *** bench/srht_stream.sv ***
// instruction stream model feeding the hazard timing block
`default_nettype none
module srht_stream (
    input wire logic clock_i,
    input wire logic enable_i,
    input wire logic ready_i,
    output var srht_pkg::srht_op_t issue_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import srht_pkg::*;
    srht_op_t q[$];
    logic rdy = 1'b0;

    // ------------------------------------------------------------
    // offer one op per cycle
    // ------------------------------------------------------------
    initial issue_o = '0;

    // spacing comes only from queued filler ops
    // an op stands until the edge that takes it, then the next one follows
    always @(negedge clock_i) begin
        if (!issue_o.valid || rdy) begin
            issue_o = (q.size() > 0) ? q.pop_front() : '0;
        end
        #1 rdy = ready_i && enable_i && issue_o.valid;
    end
endmodule
`default_nettype wire

// *** bench/srht_core_tb.sv ***
// self-checking bench for the system-register hazard timing block
`default_nettype none
module srht_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import srht_pkg::*;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic enable_i = 1'b1;
    srht_op_t issue;
    logic ready;
    srht_strobe_t strobes;
    logic [SYSREG_W-1:0] wr_n;
    logic [SYSREG_W-1:0] rd_n;
    logic hazard;
    logic [STG_W-1:0] gap;
    int err_total = 0;
    int n_tests = 0;

    // 5 ns period
    always #2.5 clock_i = ~clock_i;

    srht_core uut (.clock_i(clock_i), .reset_i(reset_i), .enable_i(enable_i),
        .issue_i(issue), .issue_ready_o(ready), .strobes_o(strobes),
        .sysreg_wr_n_o(wr_n), .sysreg_rd_n_o(rd_n), .hazard_o(hazard),
        .hazard_gap_o(gap));
    srht_stream feed (.clock_i(clock_i), .enable_i(enable_i), .ready_i(ready),
        .issue_o(issue));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk_s(input srht_strobe_t got, input srht_strobe_t exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // settle after the falling edge so the stream model has driven first
    task automatic tick(input int n);
        repeat (n) @(negedge clock_i);
        #2;
    endtask

    // queue pushes happen just after a rising edge, never racing the offer
    task automatic go();
        @(posedge clock_i);
        #1;
    endtask

    function automatic srht_op_t mk(input srht_kind_t k, input logic [4:0] n,
        input logic [4:0] d, input logic [4:0] s);
        mk = '0;
        mk.valid = 1'b1;
        mk.kind = k;
        mk.sysctl_reg_n = n;
        mk.dst = d;
        mk.dst_we = 1'b1;
        mk.src_a = s;
    endfunction

    // expected strobes for an op sitting in stage k
    function automatic srht_strobe_t exp_s(input srht_op_t op, input int k);
        srht_kind_t t;
        exp_s = '0;
        t = op.kind;
        exp_s.irq_sample = (k == 2);
        exp_s.shutdown_write = (op.shut_inst && k == 2) || (op.shut_data && k == 4);
        exp_s.sysreg_write = (t == move_to_sysreg) && (k == 5);
        exp_s.sysreg_read = (t == move_from_sysreg) && (k == 3);
        exp_s.tlb_read_src = (t == tlb_read_op) && (k == 2);
        exp_s.entry_write = (t == tlb_read_op) && (k == 5);
        exp_s.tlb_write_src = (t inside {tlb_write_indexed_op, tlb_write_random_op}) && (k == 2);
        exp_s.tlb_write = (t inside {tlb_write_indexed_op, tlb_write_random_op}) && (k == 5);
        exp_s.probe_src = (t == tlb_probe_op) && (k == 2);
        exp_s.index_write = (t == tlb_probe_op) && (k == 6);
        exp_s.ret_read = (t == exception_return_op) && (k == 2);
        exp_s.ret_flags = (t == exception_return_op) && (k == 4);
        exp_s.usable_check = (t == coproc_op) && (k == 2);
        exp_s.ldst_sample = (t == load_store_op) && (k == 3);
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_kinds();
        srht_op_t op;
        for (int i = 0; i < 12; i++) begin
            op = mk(srht_kind_t'((i < 10) ? i : 0), 5'h00, 5'h00, 5'h00);
            op.shut_inst = (i == 10);
            op.shut_data = (i == 11);
            go();
            feed.q.push_back(op);
            tick(1);
            for (int k = 1; k <= 7; k++) begin
                tick(1);
                chk_s(strobes, exp_s(op, k));
            end
        end
        $display("done: stage strobes per kind");
    endtask

    task automatic t_walk();
        go();
        feed.q.push_back(mk(move_to_sysreg, 5'h09, 5'h00, 5'h00));
        feed.q.push_back(mk(move_from_sysreg, 5'h06, 5'h00, 5'h00));
        tick(5);
        chk_v(8'(rd_n), 8'h06);
        chk_v(8'(strobes.sysreg_read), 8'h01);
        tick(1);
        chk_v(8'(wr_n), 8'h09);
        chk_v(8'(strobes.sysreg_write), 8'h01);
        tick(4);
        $display("done: register numbers");
    endtask

    task automatic t_hazard();
        srht_kind_t pk[7] = '{move_to_sysreg, move_to_sysreg, tlb_probe_op, move_to_sysreg,
            move_to_sysreg, tlb_read_op, move_to_sysreg};
        srht_kind_t ck[7] = '{move_from_sysreg, move_from_sysreg, move_from_sysreg,
            exception_return_op, exception_return_op, move_from_sysreg, move_from_sysreg};
        int fill[7] = '{0, 1, 0, 0, 1, 0, 0};
        int gexp[7] = '{1, 0, 2, 2, 1, 1, 0};
        for (int i = 0; i < 7; i++) begin
            go();
            feed.q.push_back(mk(pk[i], 5'h03, 5'h00, 5'h00));
            repeat (fill[i]) feed.q.push_back(mk(other_op, 5'h00, 5'h00, 5'h00));
            feed.q.push_back(mk(ck[i], (i == 6) ? 5'h04 : 5'h03, 5'h00, 5'h00));
            tick(fill[i] + 2);
            chk_v(8'(ready), 8'h01);
            tick(1);
            chk_v(8'(hazard), 8'(gexp[i] != 0));
            chk_v(8'(gap), 8'(gexp[i]));
            tick(6);
        end
        $display("done: filler spacing");
    endtask

    task automatic t_interlock();
        srht_kind_t pk[4] = '{load_store_op, load_store_op, move_from_sysreg, load_store_op};
        logic [4:0] d[4] = '{5'h04, 5'h00, 5'h07, 5'h04};
        logic [4:0] s[4] = '{5'h04, 5'h00, 5'h07, 5'h05};
        for (int i = 0; i < 4; i++) begin
            go();
            feed.q.push_back(mk(pk[i], 5'h01, d[i], 5'h00));
            feed.q.push_back(mk(other_op, 5'h00, 5'h00, s[i]));
            tick(2);
            chk_v(8'(ready), 8'(!(d[i] == s[i] && d[i] != 5'h00)));
            tick(1);
            chk_v(8'(ready), 8'h01);
            tick(6);
        end
        $display("done: register interlock");
    endtask

    // a frozen pipe keeps its stage, so the write lands late by the freeze
    task automatic t_enable();
        go();
        feed.q.push_back(mk(move_to_sysreg, 5'h02, 5'h00, 5'h00));
        tick(3);
        enable_i = 1'b0;
        tick(3);
        chk_v(8'(strobes.irq_sample), 8'h01);
        enable_i = 1'b1;
        tick(3);
        chk_v(8'(strobes.sysreg_write), 8'h01);
        tick(3);
        $display("done: clock enable");
    endtask

    task automatic t_reset();
        go();
        feed.q.push_back(mk(move_to_sysreg, 5'h02, 5'h00, 5'h00));
        tick(3);
        reset_i = 1'b1;
        tick(1);
        reset_i = 1'b0;
        for (int k = 0; k < 5; k++) begin
            chk_s(strobes, '0);
            tick(1);
        end
        chk_v(8'(ready), 8'h01);
        $display("done: mid-run reset");
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clock_i);
        tick(1);
        chk_s(strobes, '0);
        reset_i = 1'b0;
        t_kinds();
        t_walk();
        t_hazard();
        t_interlock();
        t_enable();
        t_reset();
        close_out();
    end

    // the tests need about 240 cycles; over eighty times that means a hang
    initial begin
        #100000;
        err_total++;
        close_out();
    end
endmodule
`default_nettype wire
